// ---- fsc_canon_chk.sv ----
// Canonical-form checker for 64-bit entry pointers
`timescale 1ns/1ns
module fsc_canon_chk
  import fsc_pkg::*;
(
  input wire logic [63:0] addr,
  output logic canonical
);

  // Upper bits beyond the implemented width must copy the top address bit
  always_comb begin
    canonical = (&addr[63:FSC_VA_BITS-1]) | ~(|addr[63:FSC_VA_BITS-1]);
  end

endmodule // fsc_canon_chk

// ---- fsc_pkg.sv ----
// Constants shared by the fast kernel entry/return target unit
// Function
// - 32-bit return: code selector equals return field
// - 64-bit return: code selector is field plus 16
// - Any return: stack selector is field plus 8
// - Entry: code selector equals entry field unchanged
// - Entry: stack selector is entry field plus 8
// - Legacy entry pointer from low 32 bits
// - 64-bit caller: pointer from long-mode register
// - Compatibility caller: pointer from compatibility register
// - Non-canonical pointer write raises protection fault
// - Long-mode entry clears flags where mask is 1
// - Flags whose mask bit is 0 stay unchanged
// - Fixed hidden segment values loaded; visible selectors from register fields
// - Privilege of targets assumed, never checked
// - Selector register fully readable and writable
package fsc_pkg;

  // Register select codes on the model register write/read port
  localparam logic [1:0] FSC_SEL_SELECTORS = 2'h0;
  localparam logic [1:0] FSC_SEL_LONG_PTR = 2'h1;
  localparam logic [1:0] FSC_SEL_COMPAT_PTR = 2'h2;
  localparam logic [1:0] FSC_SEL_FLAG_MASK = 2'h3;

  // Field positions inside fast_call_selectors
  localparam int FSC_RET_SEL_LO = 48;
  localparam int FSC_ENT_SEL_LO = 32;
  localparam int FSC_PTR32_HI = 31;

  // Selector arithmetic
  localparam logic [15:0] FSC_SS_STEP = 16'h0008;
  localparam logic [15:0] FSC_CS64_STEP = 16'h0010;

  // Reset values of the configuration registers
  localparam logic [63:0] FSC_SELECTORS_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] FSC_LONG_PTR_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] FSC_COMPAT_PTR_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] FSC_FLAG_MASK_RST = 64'h0000_0000_0000_0000;

  // Implemented virtual address width for the canonical check
  localparam int FSC_VA_BITS = 48;

  // Privilege levels assumed on entry and return
  localparam logic [1:0] FSC_PRIV_KERNEL = 2'h0;
  localparam logic [1:0] FSC_PRIV_USER = 2'h3;

  // Fixed hidden-part values of the flat segments
  localparam logic [63:0] FSC_SEG_BASE = 64'h0000_0000_0000_0000;
  localparam logic [31:0] FSC_SEG_LIMIT = 32'hFFFF_FFFF;
  localparam logic [11:0] FSC_CS_ATTR_64 = 12'hA9B;
  localparam logic [11:0] FSC_CS_ATTR_32 = 12'hC9B;
  localparam logic [11:0] FSC_SS_ATTR = 12'hC93;

  // Kind of transfer requested by the core
  typedef enum logic [1:0] {
    FSC_OP_ENTRY = 2'b01,
    FSC_OP_RETURN = 2'b10
  } fsc_op_e;

endpackage : fsc_pkg

// ---- fsc_sw_model.sv ----
// Software-side model that programs the unit's configuration registers
`timescale 1ns/1ns
module fsc_sw_model
  import fsc_pkg::*;
(
  input wire logic clk,
  output logic wr_en,
  output logic [1:0] wr_sel,
  output logic [63:0] wr_data,
  input wire logic wr_fault,
  output logic rd_en,
  output logic [1:0] rd_sel,
  input wire logic [63:0] rd_data
);
  // Bus idle at time zero
  initial begin
    wr_en = 1'b0;
    wr_sel = 2'h0;
    wr_data = 64'h0;
    rd_en = 1'b0;
    rd_sel = 2'h0;
  end

  // Selector word as careful system software builds it; the flat code
  // segment layout is the same for every process, never varied here
  function automatic logic [63:0] make_sel(input logic [63:0] v);
    make_sel = {v[63:50], 2'b11,
                v[47:34], 2'b00,
                v[31:0]};
  endfunction

  // One write; every caller follows it with a read, so the read strobe
  // rises in the very next cycle and write-then-read turnaround is used
  task automatic write_reg(input logic [1:0] sel, input logic [63:0] data,
      output logic fault);
    wr_en = 1'b1;
    wr_sel = sel;
    wr_data = data;
    @(negedge clk);
    fault = wr_fault;
    wr_en = 1'b0;
    // Released data is inverted so a stale value is never mistaken
    wr_data = ~data;
  endtask

  // One read; data is registered, seen one cycle after the strobe
  task automatic read_reg(input logic [1:0] sel, output logic [63:0] data);
    rd_en = 1'b1;
    rd_sel = sel;
    @(negedge clk);
    data = rd_data;
    rd_en = 1'b0;
    @(negedge clk);
  endtask
endmodule // fsc_sw_model

// ---- fsc_target_unit.sv ----
// Fast kernel entry/return target unit: registers and selector forming
`timescale 1ns/1ns
module fsc_target_unit
  import fsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic [63:0] wr_data,
  output logic wr_fault,
  input wire logic rd_en,
  input wire logic [1:0] rd_sel,
  output logic [63:0] rd_data,
  input wire logic op_valid,
  input wire logic [1:0] op_kind,
  input wire logic long_mode,
  input wire logic caller_64,
  input wire logic ret_to_64,
  input wire logic [63:0] flags_in,
  output logic res_valid,
  output logic [15:0] res_cs_sel,
  output logic [15:0] res_ss_sel,
  output logic [63:0] res_entry_ptr,
  output logic [63:0] res_flags,
  output logic [1:0] res_priv,
  output logic [63:0] res_seg_base,
  output logic [31:0] res_seg_limit,
  output logic [11:0] res_cs_attr,
  output logic [11:0] res_ss_attr
);

  // Configuration registers
  logic [63:0] fast_call_selectors_ff; // Return/entry selectors, 32-bit ptr
  logic [63:0] long_call_entry_pointer_ff; // Target for 64-bit callers
  logic [63:0] compat_call_entry_pointer_ff; // Target for compat callers
  logic [63:0] flag_clear_mask_ff; // Flags cleared on long-mode entry

  // Result registers
  logic wr_fault_ff;
  logic [63:0] rd_data_ff;
  logic res_valid_ff;
  logic [15:0] res_cs_sel_ff;
  logic [15:0] res_ss_sel_ff;
  logic [63:0] res_entry_ptr_ff;
  logic [63:0] res_flags_ff;
  logic [1:0] res_priv_ff;
  logic [11:0] res_cs_attr_ff;
  logic [11:0] res_ss_attr_ff;

  // Next values
  logic [15:0] nxt_cs_sel;
  logic [15:0] nxt_ss_sel;
  logic [63:0] nxt_entry_ptr;
  logic [63:0] nxt_flags;
  logic [1:0] nxt_priv;
  logic [11:0] nxt_cs_attr;
  logic [63:0] nxt_rd_data;

  // Canonical check on incoming write data
  logic wr_canonical;
  logic wr_is_ptr; // Write targets one of the 64-bit pointer registers
  logic wr_bad_ptr; // Write must be refused with a protection fault
  logic is_entry;
  logic is_return;

  // Pulls a 16-bit selector field out of the selector register
  function automatic logic [15:0] sel_field(input logic [63:0] v,
                                            input int lo);
    logic [15:0] f;
    f = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      f[i] = v[lo+i];
    end
    return f;
  endfunction

  fsc_canon_chk u_canon (
    .addr(wr_data),
    .canonical(wr_canonical)
  );

  // Request decode
  always_comb begin
    is_entry = op_valid && (op_kind == FSC_OP_ENTRY);
    is_return = op_valid && (op_kind == FSC_OP_RETURN);
    wr_is_ptr = (wr_sel == FSC_SEL_LONG_PTR) ||
                (wr_sel == FSC_SEL_COMPAT_PTR);
    wr_bad_ptr = wr_en && wr_is_ptr && !wr_canonical;
  end

  // Selector register: every bit software-writable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_call_selectors_ff <= FSC_SELECTORS_RST;
    end else if (wr_en && wr_sel == FSC_SEL_SELECTORS) begin
      // Low privilege bits are stored as written; software picks them
      fast_call_selectors_ff <= wr_data;
    end
  end

  // Long-mode pointer: a non-canonical value never lands
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      long_call_entry_pointer_ff <= FSC_LONG_PTR_RST;
    end else if (wr_en && wr_sel == FSC_SEL_LONG_PTR && wr_canonical) begin
      long_call_entry_pointer_ff <= wr_data;
    end
  end

  // Compatibility pointer: same guard as the long-mode one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compat_call_entry_pointer_ff <= FSC_COMPAT_PTR_RST;
    end else if (wr_en && wr_sel == FSC_SEL_COMPAT_PTR && wr_canonical) begin
      compat_call_entry_pointer_ff <= wr_data;
    end
  end

  // Flag clear mask
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_clear_mask_ff <= FSC_FLAG_MASK_RST;
    end else if (wr_en && wr_sel == FSC_SEL_FLAG_MASK) begin
      flag_clear_mask_ff <= wr_data;
    end
  end

  // Fault pulse one cycle after the refused write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_fault_ff <= 1'b0;
    end else begin
      wr_fault_ff <= wr_bad_ptr;
    end
  end

  // Read mux; all four selects are mapped
  always_comb begin
    unique case (rd_sel)
      FSC_SEL_SELECTORS: nxt_rd_data = fast_call_selectors_ff;
      FSC_SEL_LONG_PTR: nxt_rd_data = long_call_entry_pointer_ff;
      FSC_SEL_COMPAT_PTR: nxt_rd_data = compat_call_entry_pointer_ff;
      FSC_SEL_FLAG_MASK: nxt_rd_data = flag_clear_mask_ff;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_ff <= 64'h0000_0000_0000_0000;
    end else if (rd_en) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // Selector, pointer and flag forming; no descriptor is ever read
  // so the transfer costs one cycle, at the price of trusting software
  always_comb begin
    nxt_cs_sel = res_cs_sel_ff;
    nxt_ss_sel = res_ss_sel_ff;
    nxt_entry_ptr = res_entry_ptr_ff;
    nxt_flags = res_flags_ff;
    nxt_priv = res_priv_ff;
    nxt_cs_attr = res_cs_attr_ff;
    if (is_entry) begin
      // Entry selector copied as is, stack one descriptor above
      nxt_cs_sel = sel_field(fast_call_selectors_ff, FSC_ENT_SEL_LO);
      nxt_ss_sel = sel_field(fast_call_selectors_ff, FSC_ENT_SEL_LO)
                   + FSC_SS_STEP;
      // Kernel privilege assumed, target descriptor not consulted
      nxt_priv = FSC_PRIV_KERNEL;
      if (!long_mode) begin
        // Legacy: zero-extended 32-bit pointer, flags untouched
        nxt_entry_ptr = {32'h0000_0000,
                         fast_call_selectors_ff[FSC_PTR32_HI:0]};
        nxt_flags = flags_in;
        nxt_cs_attr = FSC_CS_ATTR_32;
      end else begin
        if (caller_64) begin
          nxt_entry_ptr = long_call_entry_pointer_ff;
        end else begin
          nxt_entry_ptr = compat_call_entry_pointer_ff;
        end
        // Mask bit 1 clears the flag, mask bit 0 keeps it
        nxt_flags = flags_in & ~flag_clear_mask_ff;
        nxt_cs_attr = FSC_CS_ATTR_64;
      end
    end else if (is_return) begin
      // User privilege assumed on every return
      nxt_priv = FSC_PRIV_USER;
      nxt_flags = flags_in;
      nxt_entry_ptr = 64'h0000_0000_0000_0000;
      nxt_ss_sel = sel_field(fast_call_selectors_ff, FSC_RET_SEL_LO)
                   + FSC_SS_STEP;
      if (ret_to_64) begin
        nxt_cs_sel = sel_field(fast_call_selectors_ff, FSC_RET_SEL_LO)
                     + FSC_CS64_STEP;
        nxt_cs_attr = FSC_CS_ATTR_64;
      end else begin
        nxt_cs_sel = sel_field(fast_call_selectors_ff, FSC_RET_SEL_LO);
        nxt_cs_attr = FSC_CS_ATTR_32;
      end
    end
  end

  // Result valid pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      res_valid_ff <= 1'b0;
    end else begin
      res_valid_ff <= is_entry || is_return;
    end
  end

  // Result fields hold their last value between requests
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      res_cs_sel_ff <= 16'h0000;
      res_ss_sel_ff <= 16'h0000;
      res_entry_ptr_ff <= 64'h0000_0000_0000_0000;
      res_flags_ff <= 64'h0000_0000_0000_0000;
      res_priv_ff <= FSC_PRIV_KERNEL;
      res_cs_attr_ff <= FSC_CS_ATTR_64;
      res_ss_attr_ff <= FSC_SS_ATTR;
    end else begin
      res_cs_sel_ff <= nxt_cs_sel;
      res_ss_sel_ff <= nxt_ss_sel;
      res_entry_ptr_ff <= nxt_entry_ptr;
      res_flags_ff <= nxt_flags;
      res_priv_ff <= nxt_priv;
      res_cs_attr_ff <= nxt_cs_attr;
      // Stack attributes are the same fixed value in every mode
      res_ss_attr_ff <= FSC_SS_ATTR;
    end
  end

  // Outputs; base and limit are fixed flat-model constants
  assign wr_fault = wr_fault_ff;
  assign rd_data = rd_data_ff;
  assign res_valid = res_valid_ff;
  assign res_cs_sel = res_cs_sel_ff;
  assign res_ss_sel = res_ss_sel_ff;
  assign res_entry_ptr = res_entry_ptr_ff;
  assign res_flags = res_flags_ff;
  assign res_priv = res_priv_ff;
  assign res_seg_base = FSC_SEG_BASE;
  assign res_seg_limit = FSC_SEG_LIMIT;
  assign res_cs_attr = res_cs_attr_ff;
  assign res_ss_attr = res_ss_attr_ff;

  // Checks against the forming logic
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_ret_cs_legacy: assert property (
    is_return && !ret_to_64 |=>
      res_valid && res_cs_sel == $past(fast_call_selectors_ff[63:48]))
    else $error("return code selector not copied from return field");

  chk_ret_cs_long: assert property (
    is_return && ret_to_64 |=>
      res_cs_sel == $past(fast_call_selectors_ff[63:48]) + 16'h0010)
    else $error("64-bit return code selector not field plus 16");

  chk_ret_ss_step: assert property (
    is_return |=>
      res_ss_sel == $past(fast_call_selectors_ff[63:48]) + 16'h0008)
    else $error("return stack selector not field plus 8");

  chk_entry_cs_copy: assert property (
    is_entry |=>
      res_valid && res_cs_sel == $past(fast_call_selectors_ff[47:32]))
    else $error("entry code selector not copied from entry field");

  chk_entry_ss_step: assert property (
    is_entry |=>
      res_ss_sel == $past(fast_call_selectors_ff[47:32]) + 16'h0008)
    else $error("entry stack selector not entry field plus 8");

  chk_legacy_ptr_low: assert property (
    is_entry && !long_mode |=>
      res_entry_ptr == {32'h0, $past(fast_call_selectors_ff[31:0])})
    else $error("legacy entry pointer not from low 32 bits");

  chk_long_ptr_src: assert property (
    is_entry && long_mode && caller_64 |=>
      res_entry_ptr == $past(long_call_entry_pointer_ff))
    else $error("64-bit caller entry pointer from wrong register");

  chk_compat_ptr_src: assert property (
    is_entry && long_mode && !caller_64 |=>
      res_entry_ptr == $past(compat_call_entry_pointer_ff))
    else $error("compatibility caller entry pointer from wrong register");

  chk_canon_fault_hold: assert property (
    wr_en && wr_is_ptr && !wr_canonical |=>
      wr_fault && $stable(long_call_entry_pointer_ff) &&
      $stable(compat_call_entry_pointer_ff))
    else $error("non-canonical pointer write not faulted or stored");

  chk_flags_cleared: assert property (
    is_entry && long_mode |=> (res_flags & $past(flag_clear_mask_ff)) == 64'h0)
    else $error("masked flag not cleared on long-mode entry");

  chk_flags_kept: assert property (
    is_entry |=> (res_flags & ~$past(flag_clear_mask_ff)) ==
      ($past(flags_in) & ~$past(flag_clear_mask_ff)))
    else $error("unmasked flag changed on entry");

  chk_priv_assumed: assert property (
    is_entry ##1 is_return |=>
      res_priv == FSC_PRIV_USER && $past(res_priv) == FSC_PRIV_KERNEL)
    else $error("assumed privilege wrong after entry then return");

  chk_selectors_readback: assert property (
    wr_en && wr_sel == FSC_SEL_SELECTORS ##1
      rd_en && rd_sel == FSC_SEL_SELECTORS && !wr_en |=>
      rd_data == $past(wr_data, 2))
    else $error("selector register does not read back written value");

  // Main scenarios
  cov_entry_long64: cover property (is_entry && long_mode && caller_64);
  cov_entry_compat: cover property (is_entry && long_mode && !caller_64);
  cov_entry_legacy: cover property (is_entry && !long_mode);
  cov_return_64: cover property (is_return && ret_to_64);
  cov_ptr_fault: cover property (wr_bad_ptr);

endmodule // fsc_target_unit

// ---- tb.sv ----
// Self-checking testbench for the fast kernel entry/return unit
`timescale 1ns/1ns
module tb
  import fsc_pkg::*;
;
  logic clk;
  logic reset_n;
  logic wr_en, rd_en, wr_fault, op_valid, long_mode, caller_64, ret_to_64;
  logic res_valid;
  logic [1:0] wr_sel, rd_sel, op_kind, res_priv;
  logic [63:0] wr_data, rd_data, flags_in, res_entry_ptr, res_flags;
  logic [63:0] res_seg_base;
  logic [15:0] res_cs_sel, res_ss_sel;
  logic [31:0] res_seg_limit;
  logic [11:0] res_cs_attr, res_ss_attr;
  int mismatches;
  int compares;
  // Expected register contents, kept by the bench
  logic [63:0] shadow [4];
  logic [63:0] rv;
  logic flt;
  logic [63:0] bad [2] = '{64'h0000_8000_0000_0000, 64'hFFFF_7FFF_FFFF_FFFF};

  fsc_target_unit DUT (.clk(clk), .reset_n(reset_n), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_data(wr_data), .wr_fault(wr_fault), .rd_en(rd_en),
    .rd_sel(rd_sel), .rd_data(rd_data), .op_valid(op_valid),
    .op_kind(op_kind), .long_mode(long_mode), .caller_64(caller_64),
    .ret_to_64(ret_to_64), .flags_in(flags_in), .res_valid(res_valid),
    .res_cs_sel(res_cs_sel), .res_ss_sel(res_ss_sel),
    .res_entry_ptr(res_entry_ptr), .res_flags(res_flags),
    .res_priv(res_priv), .res_seg_base(res_seg_base),
    .res_seg_limit(res_seg_limit), .res_cs_attr(res_cs_attr),
    .res_ss_attr(res_ss_attr));

  fsc_sw_model sw (.clk(clk), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data), .wr_fault(wr_fault), .rd_en(rd_en), .rd_sel(rd_sel),
    .rd_data(rd_data));

  // 125 MHz core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp,
      input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Entry pointer source depends on mode of the caller
  function automatic logic [63:0] exp_ptr(input logic lm, input logic c64);
    if (!lm) begin
      return {32'h0, shadow[0][31:0]};
    end
    return c64 ? shadow[1] : shadow[2];
  endfunction

  // One transfer request; left raised so requests run back to back
  task automatic do_op(input logic [1:0] kind, input logic lm,
      input logic c64, input logic r64, input logic [63:0] fl);
    logic [15:0] ret;
    logic [15:0] ent;
    ret = shadow[0][63:48];
    ent = shadow[0][47:32];
    op_valid = 1'b1;
    op_kind = kind;
    long_mode = lm;
    caller_64 = c64;
    ret_to_64 = r64;
    flags_in = fl;
    @(negedge clk);
    if (kind == FSC_OP_ENTRY) begin
      check(res_valid, 1'b1, "entry valid");
      check(res_cs_sel, ent, "entry cs");
      check(res_ss_sel, 16'(ent + 16'h0008), "entry ss");
      check(res_entry_ptr, exp_ptr(lm, c64), "entry ptr");
      check(res_flags, lm ? fl & ~shadow[3] : fl, "flags");
      check(res_priv, 2'h0, "entry priv");
      check(res_cs_attr, lm ? 12'hA9B : 12'hC9B, "entry attr");
    end else if (kind == FSC_OP_RETURN) begin
      check(res_valid, 1'b1, "return valid");
      check(res_cs_sel, 16'(r64 ? ret + 16'h0010 : ret), "return cs");
      check(res_ss_sel, 16'(ret + 16'h0008), "return ss");
      check(res_entry_ptr, 64'h0, "return ptr");
      check(res_flags, fl, "return flags");
      check(res_priv, 2'h3, "return priv");
      check(res_cs_attr, r64 ? 12'hA9B : 12'hC9B, "code attr");
    end else begin
      // Undefined kinds must not produce a result
      check(res_valid, 1'b0, "ignored kind");
    end
    check(res_seg_base, 64'h0, "seg base");
    check(res_seg_limit, 32'hFFFF_FFFF, "seg limit");
    check(res_ss_attr, 12'hC93, "stack attr");
  endtask

  initial begin
    reset_n = 1'b0;
    op_valid = 1'b0;
    op_kind = 2'h0;
    long_mode = 1'b0;
    caller_64 = 1'b0;
    ret_to_64 = 1'b0;
    flags_in = 64'h0;
    mismatches = 0;
    compares = 0;
    void'($urandom(32'hB05F8F84));
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    // Reset contents of all four registers
    for (int s = 0; s < 4; s++) begin
      sw.read_reg(s[1:0], rv);
      check(rv, 64'h0, "reset value");
    end
    $display("test reset done");
    // Program random contents, read back, then run every op mix
    for (int n = 0; n < 8; n++) begin
      for (int s = 0; s < 4; s++) begin
        rv = {$urandom, $urandom};
        if (s == 1 || s == 2) begin
          rv = {{16{rv[47]}}, rv[47:0]};
        end
        // Odd rounds use recommended privilege bits, even rounds raw ones
        if (s == 0 && n[0]) begin
          rv = sw.make_sel(rv);
        end
        sw.write_reg(s[1:0], rv, flt);
        check(flt, 1'b0, "canonical write");
        shadow[s] = rv;
        sw.read_reg(s[1:0], rv);
        check(rv, shadow[s], "readback");
      end
      for (int i = 0; i < 16; i++) begin
        do_op(i[1:0], i[2], i[3], 1'($urandom), {$urandom, $urandom});
      end
      op_valid = 1'b0;
    end
    $display("test transfers done");
    // Non-canonical pointers are refused; the edge of the range is kept
    for (int s = 1; s < 3; s++) begin
      foreach (bad[k]) begin
        sw.write_reg(s[1:0], bad[k], flt);
        check(flt, 1'b1, "non-canonical fault");
        sw.read_reg(s[1:0], rv);
        check(rv, shadow[s], "refused write kept");
      end
      sw.write_reg(s[1:0], 64'h0000_7FFF_FFFF_FFFF, flt);
      check(flt, 1'b0, "top canonical");
      sw.read_reg(s[1:0], rv);
      check(rv, 64'h0000_7FFF_FFFF_FFFF, "top stored");
    end
    $display("test faults done");
    complete_run();
  end
endmodule // tb
